//--- rtl/alwm_top.v
// Autolight event mapper, slider segmentation and doze wake-up sequencer
`include "alwm_defines.vh"

// Functional notes
// - Group event fires on any selected event; the group 0 slider bit selects segments instead
// - Second group mask spans two bytes
// - Group bits independent, all default off
// - Segment change needs percentage hysteresis, default 2
// - One hysteresis applies to every segment
// - Wake needs one to five ordered keys
// - Length zero wakes on any event
// - Length six wakes only by input/command
// - Keys are nibbles, earlier key low
// - Button or slider touch on, release off
// - Move mappings switch off on opposite move/release
// - Segment outputs split slider in equal parts
// - Lowest pin takes lowest segment
// - Code 0x0C selects first group
// - Code below twelve selects that button
// - Codes 0x0D, 0x0E, 0x0F: group1, low, high
// - Only autolit plain outputs follow mapping
module alwm_top #(
    parameter POS_W   = 8,
    parameter SLD_MAX = 255
) (
    input  wire             CLK,
    input  wire             ARST_N,
    input  wire             REG_WE,
    input  wire [7:0]       REG_ADDR,
    input  wire [7:0]       REG_WDATA,
    output reg  [7:0]       REG_RDATA,
    input  wire [11:0]      BTN_TOUCH_EV,
    input  wire [11:0]      BTN_RELEASE_EV,
    input  wire             SLD_TOUCH_EV,
    input  wire             SLD_RELEASE_EV,
    input  wire             SLD_MOVE_HIGH_EV,
    input  wire             SLD_MOVE_LOW_EV,
    input  wire             SLD_TOUCHED,
    input  wire [POS_W-1:0] SLD_POS,
    input  wire             DOZE,
    input  wire             GPI_PIN,
    input  wire             HOST_WAKE_CMD,
    output reg  [7:0]       GPO_ON,
    output reg              WAKE_REQ
);
    reg  [31:0] map_r;
    reg  [14:0] grp0_r;
    reg  [14:0] grp1_r;
    reg  [7:0]  hyst_r;
    reg  [7:0]  wsize_r;
    reg  [23:0] wkeys_r;
    reg  [15:0] mode_r;
    reg  [7:0]  auto_r;
    reg  [2:0]  widx_r;
    reg         gpi_prev_r;

    reg  [7:0]  gpo_nxt;
    reg  [7:0]  seg_sel;
    reg  [3:0]  seg_cnt;
    reg  [7:0]  rdata_nxt;

    wire        gpi_s;
    wire [2:0]  seg_idx;

    // Event vectors share the group mask layout: buttons, move low, move high, slider
    wire [14:0] on_vec  = {SLD_TOUCH_EV, SLD_MOVE_HIGH_EV, SLD_MOVE_LOW_EV, BTN_TOUCH_EV};
    wire [14:0] off_vec = {SLD_RELEASE_EV,
                           SLD_MOVE_LOW_EV | SLD_RELEASE_EV,
                           SLD_MOVE_HIGH_EV | SLD_RELEASE_EV,
                           BTN_RELEASE_EV};
    wire        any_ev  = (|on_vec) | (|off_vec);

    // Register file
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            map_r   <= {4{`ALWM_RST_BYTE}};
            grp0_r  <= 15'h0000;
            grp1_r  <= 15'h0000;
            hyst_r  <= `ALWM_RST_HYST;
            wsize_r <= `ALWM_RST_WAKE_SIZE;
            wkeys_r <= {3{`ALWM_RST_BYTE}};
            mode_r  <= {2{`ALWM_RST_BYTE}};
            auto_r  <= `ALWM_RST_AUTO;
        end else if (REG_WE) begin
            case (REG_ADDR)
                `ALWM_OFF_WAKE_SIZE: wsize_r <= REG_WDATA;
                `ALWM_OFF_WAKE_V0:   wkeys_r[23:16] <= REG_WDATA;
                `ALWM_OFF_WAKE_V1:   wkeys_r[15:8] <= REG_WDATA;
                `ALWM_OFF_WAKE_V2:   wkeys_r[7:0] <= REG_WDATA;
                `ALWM_OFF_MAP0:      map_r[31:24] <= REG_WDATA;
                `ALWM_OFF_MAP1:      map_r[23:16] <= REG_WDATA;
                `ALWM_OFF_MAP2:      map_r[15:8] <= REG_WDATA;
                `ALWM_OFF_MAP3:      map_r[7:0] <= REG_WDATA;
                `ALWM_OFF_GRP0_HI:   grp0_r[14:8] <= REG_WDATA[6:0];
                `ALWM_OFF_GRP0_LO:   grp0_r[7:0] <= REG_WDATA;
                `ALWM_OFF_GRP1_HI:   grp1_r[14:8] <= REG_WDATA[6:0];
                `ALWM_OFF_GRP1_LO:   grp1_r[7:0] <= REG_WDATA;
                `ALWM_OFF_HYST:      hyst_r <= REG_WDATA;
                `ALWM_OFF_MODE_HI:   mode_r[15:8] <= REG_WDATA;
                `ALWM_OFF_MODE_LO:   mode_r[7:0] <= REG_WDATA;
                `ALWM_OFF_AUTO:      auto_r <= REG_WDATA;
                default: begin
                end
            endcase
        end
    end

    // Reserved bit 7 of each group high byte reads as zero
    // Offset 0x50 mirrors the output states so the host can see them
    always @* begin
        case (REG_ADDR)
            `ALWM_OFF_WAKE_SIZE: rdata_nxt = wsize_r;
            `ALWM_OFF_WAKE_V0:   rdata_nxt = wkeys_r[23:16];
            `ALWM_OFF_WAKE_V1:   rdata_nxt = wkeys_r[15:8];
            `ALWM_OFF_WAKE_V2:   rdata_nxt = wkeys_r[7:0];
            `ALWM_OFF_MAP0:      rdata_nxt = map_r[31:24];
            `ALWM_OFF_MAP1:      rdata_nxt = map_r[23:16];
            `ALWM_OFF_MAP2:      rdata_nxt = map_r[15:8];
            `ALWM_OFF_MAP3:      rdata_nxt = map_r[7:0];
            `ALWM_OFF_GRP0_HI:   rdata_nxt = {1'b0, grp0_r[14:8]};
            `ALWM_OFF_GRP0_LO:   rdata_nxt = grp0_r[7:0];
            `ALWM_OFF_GRP1_HI:   rdata_nxt = {1'b0, grp1_r[14:8]};
            `ALWM_OFF_GRP1_LO:   rdata_nxt = grp1_r[7:0];
            `ALWM_OFF_HYST:      rdata_nxt = hyst_r;
            `ALWM_OFF_MODE_HI:   rdata_nxt = mode_r[15:8];
            `ALWM_OFF_MODE_LO:   rdata_nxt = mode_r[7:0];
            `ALWM_OFF_AUTO:      rdata_nxt = auto_r;
            `ALWM_OFF_OUT_STATE: rdata_nxt = GPO_ON;
            default:             rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= rdata_nxt;
        end
    end

    // Segment outputs: plain autolit pins on group 0 with the segment bit set
    // Count is recomputed every cycle, so a remap mid-touch re-splits the slider
    integer j;
    always @* begin
        seg_sel = 8'h00;
        seg_cnt = 4'd0;
        for (j = 0; j < 8; j = j + 1) begin
            if ((mode_r[2*j +: 2] == `ALWM_MODE_GPO) && auto_r[j]
                && (map_r[4*j +: 4] == `ALWM_CODE_GRP0) && grp0_r[`ALWM_SEL_SLIDER]) begin
                seg_sel[j] = 1'b1;
                seg_cnt    = seg_cnt + 4'd1;
            end
        end
    end

    alwm_seg #(
        .POS_W   (POS_W),
        .SLD_MAX (SLD_MAX)
    ) u_seg (
        .CLK      (CLK),
        .ARST_N   (ARST_N),
        .touch_ev (SLD_TOUCH_EV),
        .touched  (SLD_TOUCHED),
        .pos      (SLD_POS),
        .n_seg    (seg_cnt),
        .hyst     (hyst_r),
        .seg_r    (seg_idx)
    );

    // Per-output on/off decision
    integer   i;
    reg [3:0] code;
    reg [2:0] rank;
    reg       ev_on;
    reg       ev_off;
    always @* begin
        gpo_nxt = GPO_ON;
        rank    = 3'd0;
        code    = 4'h0;
        ev_on   = 1'b0;
        ev_off  = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            code   = map_r[4*i +: 4];
            ev_on  = 1'b0;
            ev_off = 1'b0;
            case (code)
                `ALWM_CODE_GRP0: begin
                    // Segment use expects the host to leave all other group bits clear
                    ev_on  = |(grp0_r[13:0] & on_vec[13:0]);
                    ev_off = |(grp0_r[13:0] & off_vec[13:0]);
                end
                `ALWM_CODE_GRP1: begin
                    ev_on  = |(grp1_r & on_vec);
                    ev_off = |(grp1_r & off_vec);
                end
                `ALWM_CODE_MOVE_LOW: begin
                    ev_on  = SLD_MOVE_LOW_EV;
                    ev_off = SLD_MOVE_HIGH_EV | SLD_RELEASE_EV;
                end
                `ALWM_CODE_MOVE_HIGH: begin
                    ev_on  = SLD_MOVE_HIGH_EV;
                    ev_off = SLD_MOVE_LOW_EV | SLD_RELEASE_EV;
                end
                default: begin
                    ev_on  = BTN_TOUCH_EV[code];
                    ev_off = BTN_RELEASE_EV[code];
                end
            endcase
            if ((mode_r[2*i +: 2] != `ALWM_MODE_GPO) || !auto_r[i]) begin
                gpo_nxt[i] = 1'b0;
            end else if (seg_sel[i]) begin
                gpo_nxt[i] = SLD_TOUCHED && !SLD_RELEASE_EV
                             && (seg_idx == rank);
                rank       = rank + 3'd1;
            end else if (ev_on) begin
                gpo_nxt[i] = 1'b1;
            end else if (ev_off) begin
                gpo_nxt[i] = 1'b0;
            end else begin
                gpo_nxt[i] = GPO_ON[i];
            end
        end
    end

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            GPO_ON <= 8'h00;
        end else begin
            GPO_ON <= gpo_nxt;
        end
    end

    // Wake-up path
    alwm_sync u_gpi (
        .CLK    (CLK),
        .ARST_N (ARST_N),
        .d      (GPI_PIN),
        .q_r    (gpi_s)
    );

    reg [3:0] first_btn;
    reg       btn_hit;
    integer   b;
    always @* begin
        first_btn = 4'h0;
        btn_hit   = 1'b0;
        for (b = `ALWM_NUM_BTN - 1; b >= 0; b = b - 1) begin
            if (BTN_TOUCH_EV[b]) begin
                first_btn = b[3:0];
                btn_hit   = 1'b1;
            end
        end
    end

    wire [3:0] want_key  = wkeys_r[4*widx_r +: 4];
    wire [3:0] key0      = wkeys_r[3:0];
    wire       seq_on    = (wsize_r != 8'h00) && (wsize_r < `ALWM_WAKE_OFF_LEN);
    // Edge only: an input held high wakes once, not every cycle
    wire       gpi_rise  = gpi_s && !gpi_prev_r;
    wire [7:0] next_cnt  = {5'h00, widx_r} + 8'h01;

    // Sizes above six are treated like six: only input or command wakes
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            widx_r     <= 3'd0;
            WAKE_REQ   <= 1'b0;
            gpi_prev_r <= 1'b0;
        end else begin
            gpi_prev_r <= gpi_s;
            WAKE_REQ   <= 1'b0;
            if (!DOZE) begin
                widx_r <= 3'd0;
            end else if (gpi_rise || HOST_WAKE_CMD) begin
                WAKE_REQ <= 1'b1;
                widx_r   <= 3'd0;
            end else if ((wsize_r == 8'h00) && any_ev) begin
                WAKE_REQ <= 1'b1;
            end else if (seq_on && btn_hit) begin
                if (first_btn == want_key) begin
                    if (next_cnt == wsize_r) begin
                        WAKE_REQ <= 1'b1;
                        widx_r   <= 3'd0;
                    end else begin
                        widx_r <= next_cnt[2:0];
                    end
                end else if (first_btn == key0) begin
                    // A wrong key may still start a fresh attempt
                    widx_r <= 3'd1;
                    if (wsize_r == 8'h01) begin
                        WAKE_REQ <= 1'b1;
                        widx_r   <= 3'd0;
                    end
                end else begin
                    widx_r <= 3'd0;
                end
            end
        end
    end
endmodule

//--- rtl/alwm_defines.vh
// Register offsets, reset values and mapping codes for the autolight and wake-up mapper
`ifndef ALWM_DEFINES_VH
`define ALWM_DEFINES_VH

`define ALWM_OFF_WAKE_SIZE  8'h33
`define ALWM_OFF_WAKE_V0    8'h34
`define ALWM_OFF_WAKE_V1    8'h35
`define ALWM_OFF_WAKE_V2    8'h36
`define ALWM_OFF_MAP0       8'h37
`define ALWM_OFF_MAP1       8'h38
`define ALWM_OFF_MAP2       8'h39
`define ALWM_OFF_MAP3       8'h3a
`define ALWM_OFF_GRP0_HI    8'h3b
`define ALWM_OFF_GRP0_LO    8'h3c
`define ALWM_OFF_GRP1_HI    8'h3d
`define ALWM_OFF_GRP1_LO    8'h3e
`define ALWM_OFF_HYST       8'h3f
`define ALWM_OFF_MODE_HI    8'h40
`define ALWM_OFF_MODE_LO    8'h41
`define ALWM_OFF_AUTO       8'h43
`define ALWM_OFF_OUT_STATE  8'h50

`define ALWM_RST_BYTE       8'h00
`define ALWM_RST_HYST       8'h02
`define ALWM_RST_AUTO       8'hff
`define ALWM_RST_WAKE_SIZE  8'h00

`define ALWM_CODE_GRP0      4'hc
`define ALWM_CODE_GRP1      4'hd
`define ALWM_CODE_MOVE_LOW  4'he
`define ALWM_CODE_MOVE_HIGH 4'hf
`define ALWM_NUM_BTN        12
`define ALWM_MODE_GPO       2'b00

`define ALWM_SEL_MOVE_LOW   12
`define ALWM_SEL_MOVE_HIGH  13
`define ALWM_SEL_SLIDER     14

`define ALWM_WAKE_OFF_LEN   8'h06
`define ALWM_PCT_FULL       32'd100

`endif

//--- rtl/alwm_sync.v
// Three-stage input synchroniser with agreement filter
module alwm_sync (
    input  wire CLK,
    input  wire ARST_N,
    input  wire d,
    output reg  q_r
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r  <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_r <= s3_r;
            end
        end
    end
endmodule

//--- rtl/alwm_seg.v
// Slider segment tracker with common hysteresis
`include "alwm_defines.vh"
module alwm_seg #(
    parameter POS_W   = 8,
    parameter SLD_MAX = 255
) (
    input  wire             CLK,
    input  wire             ARST_N,
    input  wire             touch_ev,
    input  wire             touched,
    input  wire [POS_W-1:0] pos,
    input  wire [3:0]       n_seg,
    input  wire [7:0]       hyst,
    output reg  [2:0]       seg_r
);
    localparam [31:0] MAXW = SLD_MAX;

    // Scale by 100*n so that no divider is needed
    wire [31:0] pos_s = {{(32-POS_W){1'b0}}, pos} * {28'h0, n_seg} * `ALWM_PCT_FULL;
    wire [31:0] hys_s = {24'h0, hyst} * MAXW * {28'h0, n_seg};
    wire [31:0] bnd_up = {29'h0, seg_r + 3'd1} * MAXW * `ALWM_PCT_FULL;
    wire [31:0] bnd_dn = {29'h0, seg_r} * MAXW * `ALWM_PCT_FULL;

    reg [2:0] raw;
    integer   k;

    always @* begin
        raw = 3'd0;
        for (k = 1; k < 8; k = k + 1) begin
            if ((k < n_seg) && (pos_s >= k * MAXW * `ALWM_PCT_FULL)) begin
                raw = k[2:0];
            end
        end
    end

    // One step per cycle is ample against the scan rate of the slider
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            seg_r <= 3'd0;
        end else if (touch_ev) begin
            seg_r <= raw;
        end else if (touched) begin
            if (({1'b0, seg_r} + 4'd1 < n_seg) && (pos_s > bnd_up + hys_s)) begin
                seg_r <= seg_r + 3'd1;
            end else if ((seg_r != 3'd0) && (pos_s + hys_s < bnd_dn)) begin
                seg_r <= seg_r - 3'd1;
            end
        end
    end
endmodule

//--- testbench/alwm_monitor.sv
// Port-level checker for the autolight mapper and wake-up sequencer
module alwm_monitor (
    input wire        CLK,
    input wire        ARST_N,
    input wire        REG_WE,
    input wire [7:0]  REG_ADDR,
    input wire [7:0]  REG_WDATA,
    input wire [7:0]  REG_RDATA,
    input wire [11:0] BTN_TOUCH_EV,
    input wire [11:0] BTN_RELEASE_EV,
    input wire        DOZE,
    input wire        GPI_PIN,
    input wire        HOST_WAKE_CMD,
    input wire [7:0]  GPO_ON,
    input wire        WAKE_REQ
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] code0_r;
    logic       auto0_r;
    logic [7:0] wsize_r;
    logic [3:0] quiet_r;
    logic       btn0;
    // Output 0 tracked only while it follows a single button
    assign btn0 = auto0_r && code0_r < 4'hc;
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            code0_r <= 4'h0;
            auto0_r <= 1'b1;
            wsize_r <= 8'h00;
            quiet_r <= 4'h0;
        end else begin
            if (REG_WE && REG_ADDR == 8'h3a) code0_r <= REG_WDATA[3:0];
            if (REG_WE && REG_ADDR == 8'h43) auto0_r <= REG_WDATA[0];
            if (REG_WE && REG_ADDR == 8'h33) wsize_r <= REG_WDATA;
            if (!$stable(GPI_PIN)) quiet_r <= 4'h0;
            else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_reset_quiet: assert property ($rose(ARST_N) |-> GPO_ON == 8'h00 && !WAKE_REQ)
        else $error("outputs not idle after reset");
    a_hyst_default: assert property (
        $rose(ARST_N) && REG_ADDR == 8'h3f |=> REG_RDATA == 8'h02)
        else $error("hysteresis reset value wrong");
    a_rsvd_bit: assert property (REG_ADDR == 8'h3d |=> !REG_RDATA[7])
        else $error("reserved bit reads one");
    a_write_read: assert property (
        REG_WE && (REG_ADDR == 8'h3e || REG_ADDR == 8'h3f)
        ##1 REG_ADDR == $past(REG_ADDR) && !REG_WE |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("readback differs from write");
    a_touch_on: assert property (btn0 && BTN_TOUCH_EV[code0_r] |=> GPO_ON[0])
        else $error("mapped touch did not light output");
    a_release_off: assert property (
        btn0 && BTN_RELEASE_EV[code0_r] && !BTN_TOUCH_EV[code0_r] |=> !GPO_ON[0])
        else $error("mapped release did not clear output");
    a_hold_state: assert property (
        btn0 && !BTN_TOUCH_EV[code0_r] && !BTN_RELEASE_EV[code0_r]
        && !REG_WE && !$past(REG_WE) |=> $stable(GPO_ON[0]))
        else $error("output changed without its event");
    a_wake_any: assert property (
        DOZE && wsize_r == 8'h00 && |BTN_TOUCH_EV |=> WAKE_REQ)
        else $error("no wake on event");
    a_wake_locked: assert property (
        DOZE && wsize_r >= 8'h06 && quiet_r > 4'h6 && !HOST_WAKE_CMD |=> !WAKE_REQ)
        else $error("sensor wake while locked");
    a_cmd_wake: assert property (DOZE && HOST_WAKE_CMD |=> WAKE_REQ)
        else $error("command did not wake");
    a_wake_single: assert property (WAKE_REQ |=> !WAKE_REQ)
        else $error("wake pulse too long");
endmodule

bind alwm_top alwm_monitor i_mon (
    .CLK(CLK), .ARST_N(ARST_N), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .BTN_TOUCH_EV(BTN_TOUCH_EV),
    .BTN_RELEASE_EV(BTN_RELEASE_EV), .DOZE(DOZE), .GPI_PIN(GPI_PIN),
    .HOST_WAKE_CMD(HOST_WAKE_CMD), .GPO_ON(GPO_ON), .WAKE_REQ(WAKE_REQ)
);

//--- testbench/alwm_sensor_model.sv
// Sensor engine stand-in: one-cycle event pulses, touch level and slider position
module alwm_sensor_model (
    input  wire         clk,
    output logic [11:0] tch,
    output logic [11:0] rel,
    output logic [3:0]  sld,
    output logic        touched,
    output logic [7:0]  pos
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tch = 12'h000;
        rel = 12'h000;
        sld = 4'h0;
        touched = 1'b0;
        pos = 8'h00;
    end
    // Kind 0/1 button touch/release, 2..5 slider touch, release, move high, move low
    task automatic ev(input int kind, input int idx);
        @(posedge clk);
        case (kind)
            0: tch[idx] <= 1'b1;
            1: rel[idx] <= 1'b1;
            default: sld[kind-2] <= 1'b1;
        endcase
        if (kind == 2) touched <= 1'b1;
        if (kind == 3) touched <= 1'b0;
        @(posedge clk);
        tch <= 12'h000;
        rel <= 12'h000;
        sld <= 4'h0;
    endtask
endmodule

//--- testbench/autolight_wakeup_mapping_tb.sv
// Self-checking bench for the autolight mapper and wake-up sequencer
module autolight_wakeup_mapping_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  addr = 8'h3f;
    logic [7:0]  wdata = 8'h00;
    logic        doze = 1'b0;
    logic        cmd = 1'b0;
    logic        general_input_pin = 1'b0;
    logic [7:0]  rdata;
    logic [7:0]  general_output_pin;
    logic        wake;
    logic [11:0] tch;
    logic [11:0] rel;
    logic [3:0]  sld;
    logic        touched;
    logic [7:0]  pos;
    logic [7:0]  op, a, b, e;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // Op 0: write a=b, read back e; op 1: event kind a on index b, outputs become e
    logic [31:0] rows [26] = '{
        32'h003dff7f, 32'h003ea5a5, 32'h003e0000, 32'h003d4040,
        32'h003c0303, 32'h003ac4c4, 32'h0039fefe, 32'h00380d0d,
        32'h003f6464, 32'h00205500, 32'h01000401, 32'h01000901,
        32'h01000103, 32'h01010402, 32'h01020012, 32'h01050016,
        32'h0104001a, 32'h01030002, 32'h01010100, 32'h00437f7f,
        32'h01000062, 32'h01010000, 32'h00410404, 32'h01000060,
        32'h00505560, 32'h01010000};
    always #50 clk = ~clk;
    alwm_sensor_model i_src (.clk(clk), .tch(tch), .rel(rel), .sld(sld), .touched(touched),
        .pos(pos));
    alwm_top i_dut (
        .CLK(clk), .ARST_N(arst_n), .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .BTN_TOUCH_EV(tch), .BTN_RELEASE_EV(rel), .SLD_TOUCH_EV(sld[0]),
        .SLD_RELEASE_EV(sld[1]), .SLD_MOVE_HIGH_EV(sld[2]), .SLD_MOVE_LOW_EV(sld[3]),
        .SLD_TOUCHED(touched), .SLD_POS(pos), .DOZE(doze), .GPI_PIN(general_input_pin),
        .HOST_WAKE_CMD(cmd), .GPO_ON(general_output_pin), .WAKE_REQ(wake));
    task automatic summarize();
        if (n_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= ad;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk);
        addr <= ad;
        @(posedge clk);
        #1 chk(rdata, exp);
    endtask
    // Bound on the run so a stuck handshake still reaches the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(8'h3f, 8'h02);
        rd_chk(8'h3e, 8'h00);
        foreach (rows[i]) begin
            {op, a, b, e} = rows[i];
            if (op == 8'h00) begin
                wr(a, b);
                rd_chk(a, e);
            end else begin
                i_src.ev(int'(a), int'(b));
                #1 chk(general_output_pin, e);
            end
        end
        @(posedge clk);
        doze <= 1'b1;
        i_src.ev(0, 9);
        #1 chk({7'h00, wake}, 8'h01);
        wr(8'h36, 8'h52);
        wr(8'h35, 8'h07);
        wr(8'h33, 8'h03);
        // A wrong first key must not count towards the sequence
        for (int k = 0; k < 4; k++) begin
            i_src.ev(0, (k == 1) ? 2 : ((k == 3) ? 7 : 5));
            #1 chk({7'h00, wake}, {7'h00, k == 3});
        end
        wr(8'h33, 8'h06);
        i_src.ev(0, 2);
        #1 chk({7'h00, wake}, 8'h00);
        @(posedge clk);
        cmd <= 1'b1;
        @(posedge clk);
        cmd <= 1'b0;
        #1 chk({7'h00, wake}, 8'h01);
        // Input edge needs the synchroniser to agree before it wakes
        @(posedge clk);
        general_input_pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({7'h00, wake}, 8'h00);
        @(posedge clk);
        #1 chk({7'h00, wake}, 8'h01);
        @(posedge clk);
        arst_n <= 1'b0;
        doze <= 1'b0;
        addr <= 8'h3f;
        @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(8'h3f, 8'h02);
        wr(8'h38, 8'hcc);
        wr(8'h3b, 8'h40);
        @(posedge clk);
        i_src.pos <= 8'h0a;
        i_src.ev(2, 0);
        repeat (3) @(posedge clk);
        #1 chk(general_output_pin, 8'h10);
        @(posedge clk);
        i_src.pos <= 8'h82;
        repeat (3) @(posedge clk);
        #1 chk(general_output_pin, 8'h10);
        @(posedge clk);
        i_src.pos <= 8'hfa;
        repeat (3) @(posedge clk);
        #1 chk(general_output_pin, 8'h20);
        @(posedge clk);
        i_src.pos <= 8'h7d;
        repeat (3) @(posedge clk);
        #1 chk(general_output_pin, 8'h20);
        i_src.ev(3, 0);
        @(posedge clk);
        #1 chk(general_output_pin, 8'h00);
        summarize();
    end
endmodule
